// ==== level_sync.sv ====
// Two-stage synchroniser for asynchronous comparator levels.
module level_sync #(
    parameter int W = 2
) (
    input  wire logic         ref_clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second one.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i; // R20
            sync_o <= meta_q;
        end
    end

    sync_delay_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        $past(nrst_i, 2) |-> sync_o == $past(async_i, 2)) // R20
        else $error("Synchroniser delay is not two cycles.");
endmodule

// ==== reg_access_if.sv ====
// Register access strobes between the bus slave and the register file.
interface reg_access_if;
    import supply_sense_pkg::*;

    logic              wr_stb;
    logic [IDX_W-1:0]  index;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;

    modport bus (output wr_stb, output index, output wdata, input rdata);
    modport regs (input wr_stb, input index, input wdata, output rdata);
endinterface

// ==== supply_sense_pkg.sv ====
// Constants, register map and field layout of the supply sense unit.
// Functional notes
// R1: Status bit 1 shows high voltage condition.
// R2: Status bit 0 shows low voltage condition.
// R3: Status register readable anytime, writes ignored.
// R4: High enable bit 1 gates high flag interrupt.
// R5: Low enable bit 0 gates low flag interrupt.
// R6: Any high condition change sets sticky flag.
// R7: Any low condition change sets sticky flag.
// R8: Flags cleared only by writing one.
// R9: Factory test registers writable only in special mode.
// R10: Interrupt request only in run mode.
// R11: Stop mode entry or exit keeps flags.
// R12: Both sense enables clear force conditions low.
// R13: Software disables interrupts before disabling sensing.
// R14: Module interrupt ORs enabled flag sources.
// R15: Two-bit field picks one of four low levels.
// R16: One bit picks one of two high levels.
// R17: Software enables sensing before trusting interrupts.
// R18: Battery pin enable wins over supply pin.
// R19: Stop mode disables sensing, keeps configuration.
// R20: Comparator outputs synchronised before use.
package supply_sense_pkg;

    localparam int DATA_W = 8;
    localparam int WB_DATA_W = 32;
    localparam int WB_ADR_W = 8;
    localparam int IDX_W = 3;

    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_CONFIG = 3'h0;
    localparam logic [IDX_W-1:0] IDX_STATUS = 3'h1;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN = 3'h2;
    localparam logic [IDX_W-1:0] IDX_FLAGS = 3'h3;
    localparam logic [IDX_W-1:0] IDX_TEST_A = 3'h6;
    localparam logic [IDX_W-1:0] IDX_TEST_B = 3'h7;

    // Field positions of the configuration register.
    localparam int BIT_BAT_SENSE = 0;
    localparam int BIT_BAT_ADC = 1;
    localparam int BIT_SUP_SENSE = 2;
    localparam int BIT_SUP_ADC = 3;
    localparam int BIT_LOW_SEL = 4;
    localparam int BIT_HIGH_SEL = 6;

    // Field positions shared by status, enable and flag registers.
    localparam int BIT_LOW = 0;
    localparam int BIT_HIGH = 1;

    // Reset values.
    localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h00;
    localparam logic [1:0] IRQ_EN_RESET = 2'h0;
    localparam logic [1:0] FLAGS_RESET = 2'h0;
    localparam logic [DATA_W-1:0] TEST_RESET = 8'h00;

endpackage

// ==== supply_sense_unit.sv ====
// Status, change flags and interrupt logic of the supply sense unit.
//
// The placing of the registers and the Wishbone register port were decided locally.
module supply_sense_unit (
    input  wire logic                                   ref_clk_i,
    input  wire logic                                   nrst_i,
    input  wire logic                                   wb_cyc_i,
    input  wire logic                                   wb_stb_i,
    input  wire logic                                   wb_we_i,
    input  wire logic [supply_sense_pkg::WB_ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]                             wb_sel_i,
    input  wire logic [supply_sense_pkg::WB_DATA_W-1:0] wb_dat_i,
    output logic      [supply_sense_pkg::WB_DATA_W-1:0] wb_dat_o,
    output logic                                        wb_ack_o,
    input  wire logic                                   cmp_high_i,
    input  wire logic                                   cmp_low_i,
    input  wire logic                                   stop_mode_i,
    input  wire logic                                   special_mode_i,
    output logic                                        battery_path_o,
    output logic                                        supply_path_o,
    output logic                                        battery_selected_o,
    output logic                                        adc_connect_o,
    output logic      [1:0]                             low_threshold_select_o,
    output logic                                        high_threshold_select_o,
    output logic                                        module_irq_o
);
    import supply_sense_pkg::*;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave and comparator synchroniser.

    reg_access_if rif ();

    wb_reg_slave u_slave (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .wb_cyc_i  (wb_cyc_i),
        .wb_stb_i  (wb_stb_i),
        .wb_we_i   (wb_we_i),
        .wb_adr_i  (wb_adr_i),
        .wb_sel_i  (wb_sel_i),
        .wb_dat_i  (wb_dat_i),
        .wb_dat_o  (wb_dat_o),
        .wb_ack_o  (wb_ack_o),
        .rb        (rif.bus)
    );

    logic [1:0] cmp_sync;

    level_sync #(
        .W (2)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .async_i   ({cmp_high_i, cmp_low_i}),
        .sync_o    (cmp_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    logic             bat_sense_q;
    logic             bat_adc_q;
    logic             sup_sense_q;
    logic             sup_adc_q;
    logic [1:0]       low_sel_q;
    logic             high_sel_q;
    logic [1:0]       irq_en_q;
    logic [1:0]       flags_q;
    logic [1:0]       flags_d;
    logic [1:0]       cond_q;
    logic [1:0]       cond_d;
    logic [DATA_W-1:0] test_q [2];

    // Write decode.
    logic       wr_config;
    logic       wr_irq_en;
    logic       wr_flags;
    logic       wr_test_a;
    logic       wr_test_b;
    logic [1:0] flag_clear;
    logic       sense_on;
    logic       new_bat_sense;
    logic       new_bat_adc;

    assign wr_config = rif.wr_stb & (rif.index == IDX_CONFIG);
    assign wr_irq_en = rif.wr_stb & (rif.index == IDX_IRQ_EN);
    assign wr_flags = rif.wr_stb & (rif.index == IDX_FLAGS);
    // Factory test storage only accepts writes in special mode.
    assign wr_test_a = rif.wr_stb & (rif.index == IDX_TEST_A)
                       & special_mode_i; // R9
    assign wr_test_b = rif.wr_stb & (rif.index == IDX_TEST_B)
                       & special_mode_i; // R9
    assign flag_clear = wr_flags ? rif.wdata[1:0] : 2'h0; // R8
    assign new_bat_sense = rif.wdata[BIT_BAT_SENSE];
    assign new_bat_adc = rif.wdata[BIT_BAT_ADC];

    // Configuration: a battery pin bit set in the same write clears the
    // matching supply pin bit, so only one pin is ever sensed.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bat_sense_q <= CONFIG_RESET[BIT_BAT_SENSE];
            bat_adc_q <= CONFIG_RESET[BIT_BAT_ADC];
            sup_sense_q <= CONFIG_RESET[BIT_SUP_SENSE];
            sup_adc_q <= CONFIG_RESET[BIT_SUP_ADC];
            low_sel_q <= CONFIG_RESET[BIT_LOW_SEL +: 2];
            high_sel_q <= CONFIG_RESET[BIT_HIGH_SEL];
        end else if (wr_config) begin
            bat_sense_q <= new_bat_sense;
            bat_adc_q <= new_bat_adc;
            sup_sense_q <= rif.wdata[BIT_SUP_SENSE] & ~new_bat_sense; // R18
            sup_adc_q <= rif.wdata[BIT_SUP_ADC] & ~new_bat_adc;
            low_sel_q <= rif.wdata[BIT_LOW_SEL +: 2]; // R15
            high_sel_q <= rif.wdata[BIT_HIGH_SEL]; // R16
        end
    end

    // Interrupt enables.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_en_q <= IRQ_EN_RESET;
        end else if (wr_irq_en) begin
            irq_en_q <= rif.wdata[1:0];
        end
    end

    // Factory test storage.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            test_q[0] <= TEST_RESET;
            test_q[1] <= TEST_RESET;
        end else begin
            if (wr_test_a) begin
                test_q[0] <= rif.wdata;
            end
            if (wr_test_b) begin
                test_q[1] <= rif.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Condition status and change flags.

    // In stop mode the status is frozen rather than forced low, so that
    // entering stop never sets a flag by itself.
    assign sense_on = bat_sense_q | sup_sense_q;
    assign cond_d = stop_mode_i ? cond_q : // R11
                    (sense_on ? cmp_sync : 2'h0); // R1 R2 R12

    // A change in the same cycle as a clear keeps the flag set.
    assign flags_d = (flags_q & ~flag_clear) | (cond_d ^ cond_q); // R6 R7 R8

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cond_q <= 2'h0;
            flags_q <= FLAGS_RESET;
        end else begin
            cond_q <= cond_d;
            flags_q <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux. Unused bits and the two spare registers read as zero.

    logic [DATA_W-1:0] config_rd;

    assign config_rd = {1'b0, high_sel_q, low_sel_q, sup_adc_q, sup_sense_q,
                        bat_adc_q, bat_sense_q};
    assign rif.rdata = (rif.index == IDX_CONFIG) ? config_rd :
                       (rif.index == IDX_STATUS) ? {6'h00, cond_q} : // R3
                       (rif.index == IDX_IRQ_EN) ? {6'h00, irq_en_q} :
                       (rif.index == IDX_FLAGS)  ? {6'h00, flags_q} :
                       (rif.index == IDX_TEST_A) ? test_q[0] :
                       (rif.index == IDX_TEST_B) ? test_q[1] : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Outputs to the analog side and the processor.

    logic irq_d;

    assign irq_d = |(flags_q & irq_en_q) & ~stop_mode_i; // R4 R5 R10 R14

    // Stop mode opens both divider paths but leaves configuration intact.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            battery_path_o <= 1'b0;
            supply_path_o <= 1'b0;
            battery_selected_o <= 1'b0;
            adc_connect_o <= 1'b0;
            low_threshold_select_o <= 2'h0;
            high_threshold_select_o <= 1'b0;
            module_irq_o <= 1'b0;
        end else begin
            battery_path_o <= (bat_sense_q | bat_adc_q) & ~stop_mode_i; // R19
            supply_path_o <= (sup_sense_q | sup_adc_q) & ~stop_mode_i; // R19
            battery_selected_o <= bat_sense_q; // R18
            adc_connect_o <= (bat_adc_q | sup_adc_q) & ~stop_mode_i;
            low_threshold_select_o <= low_sel_q; // R15
            high_threshold_select_o <= high_sel_q; // R16
            module_irq_o <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    high_status_a: assert property ( // R1
        !stop_mode_i && sense_on |=> cond_q[BIT_HIGH] == $past(cmp_sync[1]))
        else $error("High condition does not follow the comparator.");

    low_status_a: assert property ( // R2
        !stop_mode_i && sense_on |=> cond_q[BIT_LOW] == $past(cmp_sync[0]))
        else $error("Low condition does not follow the comparator.");

    status_readonly_a: assert property ( // R3
        rif.wr_stb && rif.index == IDX_STATUS && !stop_mode_i && sense_on
        |=> cond_q == $past(cmp_sync))
        else $error("Status register changed on a write.");

    irq_merge_a: assert property ( // R14
        |(flags_q & irq_en_q) && !stop_mode_i |=> module_irq_o)
        else $error("Enabled flag did not raise the interrupt.");

    irq_gate_a: assert property ( // R4
        (flags_q & irq_en_q) == 2'h0 |=> !module_irq_o)
        else $error("Interrupt raised with no enabled flag.");

    high_flag_set_a: assert property ( // R6
        $changed(cond_q[BIT_HIGH]) |-> flags_q[BIT_HIGH])
        else $error("High change did not set its flag.");

    low_flag_set_a: assert property ( // R7
        $changed(cond_q[BIT_LOW]) |-> flags_q[BIT_LOW])
        else $error("Low change did not set its flag.");

    flag_hold_a: assert property ( // R8
        flags_q[BIT_LOW] && !flag_clear[BIT_LOW] |=> flags_q[BIT_LOW])
        else $error("Low flag cleared without a write of one.");

    flag_clear_a: assert property ( // R8
        flag_clear[BIT_HIGH] && cond_d[BIT_HIGH] == cond_q[BIT_HIGH]
        |=> !flags_q[BIT_HIGH])
        else $error("High flag not cleared by a write of one.");

    test_lock_a: assert property ( // R9
        !special_mode_i |=> $stable(test_q[0]) && $stable(test_q[1]))
        else $error("Test register written outside special mode.");

    stop_irq_a: assert property ( // R10
        stop_mode_i |=> !module_irq_o)
        else $error("Interrupt raised in stop mode.");

    stop_flags_a: assert property ( // R11
        stop_mode_i && flag_clear == 2'h0 |=> $stable(flags_q))
        else $error("Flags changed across stop mode.");

    force_zero_a: assert property ( // R12
        !sense_on && !stop_mode_i |=> cond_q == 2'h0)
        else $error("Conditions not forced low with sensing off.");

    threshold_sel_a: assert property ( // R15
        wr_config |=> ##1 low_threshold_select_o == $past(rif.wdata[5:4], 2))
        else $error("Low threshold select not applied.");

    stop_path_a: assert property ( // R19
        stop_mode_i |=> !battery_path_o && !supply_path_o && $stable(low_sel_q))
        else $error("Divider path left closed in stop mode.");

    pin_priority_a: assert property ( // R18
        bat_sense_q |-> !sup_sense_q)
        else $error("Both sense pins enabled at once.");
endmodule

// ==== supply_sense_unit_bench.sv ====
// Self-checking bench of the supply sense unit with a comparator model.
module supply_sense_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import supply_sense_pkg::*;

    localparam int LB = 500;
    localparam int LS = 100;
    localparam int HB = 1500;
    localparam int HS = 200;

    logic                 ref_clk;
    logic                 nrst;
    logic                 wb_cyc;
    logic                 wb_stb;
    logic                 wb_we;
    logic [WB_ADR_W-1:0]  wb_adr;
    logic [WB_DATA_W-1:0] wb_wdat;
    logic [WB_DATA_W-1:0] wb_rdat;
    logic                 wb_ack;
    logic [3:0]           wb_sel;
    logic                 adc_on;
    logic                 cmp_high;
    logic                 cmp_low;
    logic                 stop_mode;
    logic                 special_mode;
    logic                 bat_path;
    logic                 sup_path;
    logic                 bat_sel;
    logic [1:0]           low_sel;
    logic                 high_sel;
    logic                 irq;
    logic [15:0]          battery_mv;
    logic [15:0]          supply_mv;
    logic [7:0]           rd;
    logic [7:0]           cfg;
    logic [7:0]           st;
    logic [7:0]           flags_e;
    logic [7:0]           en;
    logic [7:0]           mask;
    int                   n_errors;
    int                   comparisons;
    int                   seed;

    supply_sense_unit DUT (.ref_clk_i(ref_clk), .nrst_i(nrst),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .cmp_high_i(cmp_high),
        .cmp_low_i(cmp_low), .stop_mode_i(stop_mode),
        .special_mode_i(special_mode), .battery_path_o(bat_path),
        .supply_path_o(sup_path), .battery_selected_o(bat_sel),
        .adc_connect_o(adc_on), .low_threshold_select_o(low_sel),
        .high_threshold_select_o(high_sel), .module_irq_o(irq));

    voltage_comparator_model #(.LOW_BASE(LB), .LOW_STEP(LS),
        .HIGH_BASE(HB), .HIGH_STEP(HS)) comparators (
        .battery_selected_i(bat_sel), .battery_path_i(bat_path),
        .supply_path_i(sup_path), .low_sel_i(low_sel),
        .high_sel_i(high_sel), .battery_mv_i(battery_mv),
        .supply_mv_i(supply_mv), .cmp_high_o(cmp_high), .cmp_low_o(cmp_low));

    // Free-running bus clock at 50 MHz.
    always #10 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    // Expectation helpers.
    function automatic logic [7:0] reg_adr(input logic [IDX_W-1:0] idx);
        return {3'h0, idx, 2'h0};
    endfunction

    // A supply bit only sticks when its battery twin is clear in the word.
    function automatic logic [7:0] stored_cfg(input logic [7:0] w);
        logic [7:0] c;
        c = w & 8'h7f;
        if (w[0]) c[2] = 1'b0;
        if (w[1]) c[3] = 1'b0;
        return c;
    endfunction

    // Comparator levels for the path a stored word selects, sensing or not.
    function automatic logic [1:0] raw_cmp(input logic [7:0] c);
        int v;
        v = 0;
        if (c[0]) v = int'(battery_mv);
        else if (c[2] | c[3]) v = int'(supply_mv);
        return {v >= HB + int'(c[6]) * HS, v < LB + int'(c[5:4]) * LS};
    endfunction

    function automatic logic [7:0] exp_status(input logic [7:0] c);
        return (c[0] | c[2]) ? {6'h0, raw_cmp(c)} : 8'h00;
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One classic cycle: the request stands until ack is sampled high at a
    // rising edge, data is taken there, then the bus idles one cycle.
    task automatic wb_cycle(input logic we, input logic [7:0] adr,
                            input logic [7:0] wd, output logic [7:0] rdat);
        int i;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hf;
        wb_adr <= adr;
        wb_wdat <= {24'h0, wd};
        rdat = 8'h00;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (wb_ack === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            $display("wrong value at %0t: bus never answered", $time);
            complete_run();
        end else begin
            rdat = wb_rdat[7:0];
            wb_cyc <= 1'b0;
            wb_stb <= 1'b0;
            wb_we <= 1'b0;
            wb_sel <= 4'h0;
            @(posedge ref_clk);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Tracks change flags from each settled status step.
    task automatic step_status;
        logic [7:0] s;
        s = exp_status(cfg);
        flags_e = flags_e | (s ^ st);
        st = s;
    endtask

    // Switching sensing on first shows the old path's synchronised result
    // for a few cycles, which can set a flag of its own.
    task automatic step_stale(input logic [7:0] c_new);
        if (c_new[0] | c_new[2]) begin
            flags_e = flags_e | ({6'h0, raw_cmp(cfg)} ^ st);
            st = {6'h0, raw_cmp(cfg)};
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        {wb_cyc, wb_stb, wb_we, stop_mode, special_mode} = 5'h00;
        wb_sel = 4'h0;
        wb_adr = 8'h00;
        wb_wdat = 32'h0;
        battery_mv = 16'h0000;
        supply_mv = 16'h0000;
        n_errors = 0;
        comparisons = 0;
        seed = 32'h5005;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            wb_cycle(1'b0, reg_adr(3'(i)), 8'h00, rd);
            check(rd, 8'h00, "reset value");
        end
        $display("test reset values done");
        // Factory test register guarded by special mode; holes read zero.
        wb_cycle(1'b1, reg_adr(IDX_TEST_A), 8'ha5, rd);
        wb_cycle(1'b0, reg_adr(IDX_TEST_A), 8'h00, rd);
        check(rd, 8'h00, "test reg outside special");
        special_mode <= 1'b1;
        wb_cycle(1'b1, reg_adr(IDX_TEST_B), 8'h5a, rd);
        wb_cycle(1'b0, reg_adr(IDX_TEST_B), 8'h00, rd);
        check(rd, 8'h5a, "test reg in special");
        special_mode <= 1'b0;
        wb_cycle(1'b1, 8'h21, 8'hff, rd);
        wb_cycle(1'b0, 8'h21, 8'h00, rd);
        check(rd, 8'h00, "unmapped read");
        $display("test reserved space done");
        // Random configuration, voltages, enables and clears.
        st = 8'h00;
        flags_e = 8'h00;
        cfg = 8'h00;
        for (int k = 0; k < 24; k++) begin
            rd = 8'($random(seed));
            if (k == 0) rd = 8'h05;
            step_stale(stored_cfg(rd));
            cfg = stored_cfg(rd);
            wb_cycle(1'b1, reg_adr(IDX_CONFIG), rd, rd);
            settle(6);
            step_status();
            battery_mv <= 16'($random(seed)) & 16'h07ff;
            supply_mv <= 16'($random(seed)) & 16'h07ff;
            settle(6);
            step_status();
            wb_cycle(1'b1, reg_adr(IDX_STATUS), 8'($random(seed)), rd);
            wb_cycle(1'b0, reg_adr(IDX_STATUS), 8'h00, rd);
            check(rd, st, "status");
            wb_cycle(1'b0, reg_adr(IDX_CONFIG), 8'h00, rd);
            check(rd, cfg, "config");
            check({5'h0, high_sel, low_sel}, {5'h0, cfg[6:4]}, "thresh");
            check({7'h0, bat_sel}, {7'h0, cfg[0]}, "pin select");
            check({5'h0, adc_on, bat_path, sup_path}, {5'h0, cfg[1] | cfg[3],
                  cfg[0] | cfg[1], cfg[2] | cfg[3]}, "paths");
            en = 8'($random(seed)) & 8'h03;
            mask = 8'($random(seed)) & 8'h03;
            wb_cycle(1'b1, reg_adr(IDX_IRQ_EN), en, rd);
            wb_cycle(1'b0, reg_adr(IDX_FLAGS), 8'h00, rd);
            check(rd, flags_e, "flags set");
            wb_cycle(1'b1, reg_adr(IDX_FLAGS), mask, rd);
            flags_e = flags_e & ~mask;
            wb_cycle(1'b0, reg_adr(IDX_FLAGS), 8'h00, rd);
            check(rd, flags_e, "flags after clear");
            @(negedge ref_clk);
            check({7'h0, irq}, {7'h0, |(flags_e & en)}, "irq");
            @(posedge ref_clk);
        end
        $display("test random traffic done");
        // Stop mode hides the request but keeps flags and configuration.
        wb_cycle(1'b1, reg_adr(IDX_IRQ_EN), 8'h00, rd);
        wb_cycle(1'b1, reg_adr(IDX_CONFIG), 8'h00, rd);
        settle(6);
        wb_cycle(1'b1, reg_adr(IDX_FLAGS), 8'h03, rd);
        battery_mv <= 16'h0000;
        wb_cycle(1'b1, reg_adr(IDX_IRQ_EN), 8'h03, rd);
        wb_cycle(1'b1, reg_adr(IDX_CONFIG), 8'h01, rd);
        settle(6);
        wb_cycle(1'b0, reg_adr(IDX_FLAGS), 8'h00, rd);
        check(rd, 8'h01, "low flag");
        stop_mode <= 1'b1;
        settle(3);
        @(negedge ref_clk);
        check({7'h0, irq}, 8'h00, "irq in stop");
        check({6'h0, adc_on, bat_path}, 8'h00, "path in stop");
        @(posedge ref_clk);
        wb_cycle(1'b0, reg_adr(IDX_FLAGS), 8'h00, rd);
        check(rd, 8'h01, "flags in stop");
        wb_cycle(1'b0, reg_adr(IDX_CONFIG), 8'h00, rd);
        check(rd, 8'h01, "config in stop");
        stop_mode <= 1'b0;
        settle(6);
        @(negedge ref_clk);
        check({7'h0, irq}, 8'h01, "irq after stop");
        @(posedge ref_clk);
        wb_cycle(1'b0, reg_adr(IDX_FLAGS), 8'h00, rd);
        check(rd, 8'h01, "flags after stop");
        $display("test stop mode done");
        complete_run();
    end
endmodule

// ==== voltage_comparator_model.sv ====
// Behavioural model of the two analog voltage comparators.
module voltage_comparator_model #(
    parameter int LOW_BASE  = 500,
    parameter int LOW_STEP  = 100,
    parameter int HIGH_BASE = 1500,
    parameter int HIGH_STEP = 200
) (
    input  wire logic        battery_selected_i,
    input  wire logic        battery_path_i,
    input  wire logic        supply_path_i,
    input  wire logic [1:0]  low_sel_i,
    input  wire logic        high_sel_i,
    input  wire logic [15:0] battery_mv_i,
    input  wire logic [15:0] supply_mv_i,
    output logic             cmp_high_o,
    output logic             cmp_low_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        path_closed;
    logic [15:0] seen_mv;

    // An open divider leaves the comparator input at ground, not floating.
    assign path_closed = battery_selected_i ? battery_path_i : supply_path_i;
    assign seen_mv = !path_closed ? 16'h0000 :
                     (battery_selected_i ? battery_mv_i : supply_mv_i);
    assign cmp_low_o = int'(seen_mv) < LOW_BASE + int'(low_sel_i) * LOW_STEP;
    assign cmp_high_o = int'(seen_mv) >= HIGH_BASE + int'(high_sel_i) * HIGH_STEP;
endmodule

// ==== wb_reg_slave.sv ====
// Classic Wishbone slave that turns bus cycles into register strobes.
module wb_reg_slave (
    input  wire logic                                   ref_clk_i,
    input  wire logic                                   nrst_i,
    input  wire logic                                   wb_cyc_i,
    input  wire logic                                   wb_stb_i,
    input  wire logic                                   wb_we_i,
    input  wire logic [supply_sense_pkg::WB_ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]                             wb_sel_i,
    input  wire logic [supply_sense_pkg::WB_DATA_W-1:0] wb_dat_i,
    output logic      [supply_sense_pkg::WB_DATA_W-1:0] wb_dat_o,
    output logic                                        wb_ack_o,
    reg_access_if.bus                                   rb
);
    import supply_sense_pkg::*;

    logic req;
    logic mapped;

    // Only word-aligned addresses inside the eight-register window map.
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign mapped = (wb_adr_i[WB_ADR_W-1:5] == '0) & (wb_adr_i[1:0] == 2'h0);
    assign rb.index = wb_adr_i[4:2];
    assign rb.wdata = wb_dat_i[DATA_W-1:0];
    assign rb.wr_stb = req & wb_we_i & wb_sel_i[0] & mapped;

    // Ack follows one cycle after the request; unmapped reads return zero.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            if (req & ~wb_we_i & mapped) begin
                wb_dat_o <= {{(WB_DATA_W-DATA_W){1'b0}}, rb.rdata};
            end else begin
                wb_dat_o <= '0;
            end
        end
    end

    sequence req_s;
        wb_cyc_i & wb_stb_i & ~wb_ack_o;
    endsequence

    sequence ack_pulse_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    bus_ack_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        req_s |=> ack_pulse_s)
        else $error("Ack did not pulse one cycle after request.");
endmodule
